// file: ccc_core_control.sv
// control and test-mode logic of a can protocol core
//
// How it works
// R01: test register writable only in test mode
// R02: protected bits writable when config enable and hold
// R03: retransmit_disable stops automatic resend
// R04: error flags change loads status code
// R05: new last_error_code not 7 loads status
// R06: interrupt line follows nonzero identifier
// R07: bus-off entry sets the hold bit
// R08: hold toggling never shortens recovery
// R09: recovery counts 129 idles of 11 bits
// R10: recovery end clears error counters
// R11: test functions combine, tx mode disrupts
// R12: host clears test register before leaving
// R13: test bit 7 shows live receive pin
// R14: rx bit unreset, other test bits zero
// R15: tx control selects core, sample, 0, 1
// R16: listen-only bit puts module silent
`timescale 1ns/100ps
module ccc_core_control #(
  parameter int IDLE_BITS  = ccc_pkg::IDLE_BITS,  // bits per bus idle
  parameter int IDLE_COUNT = ccc_pkg::IDLE_COUNT  // idles per recovery
) (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic        bus_off_flag,
  input  wire logic        error_warning_flag,
  input  wire logic        code_wr,
  input  wire logic [2:0]  last_error_code,
  input  wire logic        irq_clear,
  input  wire logic        bit_tick,
  input  wire logic        core_tx,
  input  wire logic        sample_point,
  input  wire logic        bus_receive_pin,
  output logic             bus_transmit_pin,
  output logic [15:0]      irq_identifier,
  output logic             can_int,
  output logic             config_write_ok,
  output logic             retransmit_disable,
  output logic             loopback_enable,
  output logic             listen_only,
  output logic             basic_mode,
  output logic             bus_halt,
  output logic             err_cnt_clear
);
  // ************************************************************
  // elaboration checks
  // ************************************************************
  if (IDLE_BITS < 1 || IDLE_BITS > 15)
    $error("IDLE_BITS must be 1 to 15");
  if (IDLE_COUNT < 1 || IDLE_COUNT > 255)
    $error("IDLE_COUNT must be 1 to 255");

  localparam logic [3:0] BIT_LAST  = 4'(IDLE_BITS - 1);
  localparam logic [7:0] IDLE_LAST = 8'(IDLE_COUNT - 1);

  logic [7:0]  ctrl_r;       // core_control storage
  logic [7:0]  test_r;       // writable test_control bits
  logic        busoff_d_r;   // bus-off flag of last cycle
  logic        warn_d_r;     // warning flag of last cycle
  logic        hold_bit;     // setup hold bit of core_control
  logic        recover_r;    // bus-off recovery pending
  logic [3:0]  bit_cnt_r;    // consecutive recessive bits
  logic [7:0]  idle_cnt_r;   // bus idles seen so far
  logic        idle_done;    // last bit of the last idle
  logic        wr_ctrl;      // host writes core_control
  logic        wr_test;      // host writes test_control

  // ************************************************************
  // write decode
  // ************************************************************
  assign wr_ctrl = reg_wr && reg_addr == ccc_pkg::CORE_CONTROL_ADDR;
  // R01: gate test writes
  assign wr_test = reg_wr && reg_addr == ccc_pkg::TEST_CONTROL_ADDR
                   && ctrl_r[ccc_pkg::CC_TEST];

  // control register; bus-off entry forces the hold bit over the host
  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl_r <= ccc_pkg::CC_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= reg_wdata & ccc_pkg::CC_MASK;
      end
      // R07: bus-off sets hold
      if (bus_off_flag && !busoff_d_r) begin
        ctrl_r[ccc_pkg::CC_INIT] <= 1'b1;
      end
    end
  end

  // test register; rx bit is never stored, so it has no reset value
  always_ff @(posedge clock) begin
    if (srst) begin
      // R14: test bits reset zero
      test_r <= ccc_pkg::TC_RESET;
    end else if (wr_test) begin
      // R11: functions combine freely
      test_r <= reg_wdata & ccc_pkg::TC_MASK;
    end
  end

  // ************************************************************
  // mode outputs
  // ************************************************************
  // R02: protected write window
  assign config_write_ok = ctrl_r[ccc_pkg::CC_CFG_EN]
                           && ctrl_r[ccc_pkg::CC_INIT];
  assign hold_bit        = ctrl_r[ccc_pkg::CC_INIT];
  // R03: retransmission control
  assign retransmit_disable = ctrl_r[ccc_pkg::CC_NO_RETX];
  assign loopback_enable    = test_r[ccc_pkg::TC_LOOP];
  // R16: silent mode select
  assign listen_only        = test_r[ccc_pkg::TC_SIL];
  assign basic_mode         = test_r[ccc_pkg::TC_BASIC];
  // halt while held and until recovery has fully run
  assign bus_halt = ctrl_r[ccc_pkg::CC_INIT] || recover_r;

  // ************************************************************
  // read path, one cycle after the address
  // ************************************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        ccc_pkg::CORE_CONTROL_ADDR: begin
          reg_rdata <= ctrl_r;
        end
        ccc_pkg::TEST_CONTROL_ADDR: begin
          // R13: live receive level
          reg_rdata <= {bus_receive_pin, test_r[ccc_pkg::TC_RX-1:0]};
        end
        default: begin
          reg_rdata <= 8'h00;  // unmapped reads zero
        end
      endcase
    end
  end

  // ************************************************************
  // transmit pin
  // ************************************************************
  // registered so the pin never glitches between modes
  always_ff @(posedge clock) begin
    if (srst) begin
      bus_transmit_pin <= 1'b1;
    end else begin
      // R15: transmit pin select
      case (test_r[ccc_pkg::TC_TX_HI:ccc_pkg::TC_TX_LO])
        ccc_pkg::TX_CORE:     bus_transmit_pin <= core_tx;
        ccc_pkg::TX_SAMPLE:   bus_transmit_pin <= sample_point;
        ccc_pkg::TX_DOMINANT: bus_transmit_pin <= 1'b0;
        default:              bus_transmit_pin <= 1'b1;
      endcase
    end
  end

  // ************************************************************
  // status interrupt
  // ************************************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      busoff_d_r <= 1'b0;
      warn_d_r   <= 1'b0;
    end else begin
      busoff_d_r <= bus_off_flag;
      warn_d_r   <= error_warning_flag;
    end
  end

  // a new event wins over a clear in the same cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      irq_identifier <= 16'h0000;
    end else if (ctrl_r[ccc_pkg::CC_ERR_IE]
                 && (bus_off_flag != busoff_d_r
                     || error_warning_flag != warn_d_r)) begin
      // R04: error flag change
      irq_identifier <= ccc_pkg::IRQ_STATUS;
    end else if (ctrl_r[ccc_pkg::CC_STAT_IE] && code_wr
                 && last_error_code != ccc_pkg::CODE_UNUSED) begin
      // R05: last error code
      irq_identifier <= ccc_pkg::IRQ_STATUS;
    end else if (irq_clear) begin
      irq_identifier <= 16'h0000;
    end
  end

  // R06: interrupt line
  assign can_int = ctrl_r[ccc_pkg::CC_MIE] && irq_identifier != 16'h0000;

  // ************************************************************
  // bus-off recovery
  // ************************************************************
  // counting runs only with the hold bit clear; re-setting it pauses
  // but never restarts or skips, so the sequence cannot be shortened
  assign idle_done = bit_tick && bus_receive_pin && !hold_bit
                     && bit_cnt_r == BIT_LAST && idle_cnt_r == IDLE_LAST;

  always_ff @(posedge clock) begin
    if (srst) begin
      recover_r  <= 1'b0;
      bit_cnt_r  <= 4'h0;
      idle_cnt_r <= 8'h00;
    end else if (bus_off_flag && !busoff_d_r) begin
      recover_r  <= 1'b1;
      bit_cnt_r  <= 4'h0;
      idle_cnt_r <= 8'h00;
    end else if (recover_r && !ctrl_r[ccc_pkg::CC_INIT] && bit_tick) begin
      // R08: no shortcut
      if (!bus_receive_pin) begin
        bit_cnt_r <= 4'h0;  // dominant bit breaks the idle
      // R09: count bus idles
      end else if (bit_cnt_r == BIT_LAST) begin
        bit_cnt_r  <= 4'h0;
        idle_cnt_r <= idle_cnt_r + 8'h01;
        if (idle_cnt_r == IDLE_LAST) begin
          recover_r <= 1'b0;
        end
      end else begin
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
    end
  end

  // R10: clear error counters
  always_ff @(posedge clock) begin
    if (srst) begin
      err_cnt_clear <= 1'b0;
    end else begin
      err_cnt_clear <= recover_r && idle_done;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  a_test_wr_gate: assert property (@(posedge clock) disable iff (srst) // R01
    reg_wr && reg_addr == ccc_pkg::TEST_CONTROL_ADDR
    && !ctrl_r[ccc_pkg::CC_TEST] |=> $stable(test_r))
    else $error("test register changed outside test mode");
  a_prot_window: assert property (@(posedge clock) disable iff (srst) // R02
    wr_ctrl && !reg_wdata[ccc_pkg::CC_INIT]
    && !(bus_off_flag && !busoff_d_r) |=> !config_write_ok)
    else $error("protected window open without hold");
  a_eie_load: assert property (@(posedge clock) disable iff (srst) // R04
    ctrl_r[ccc_pkg::CC_ERR_IE] && error_warning_flag != warn_d_r
    |=> irq_identifier == ccc_pkg::IRQ_STATUS)
    else $error("warning change did not load status code");
  a_sie_load: assert property (@(posedge clock) disable iff (srst) // R05
    !ctrl_r[ccc_pkg::CC_ERR_IE] && !ctrl_r[ccc_pkg::CC_STAT_IE]
    && !irq_clear |=> $stable(irq_identifier))
    else $error("identifier changed with both enables clear");
  a_irq_line: assert property (@(posedge clock) disable iff (srst) // R06
    !ctrl_r[ccc_pkg::CC_MIE] |-> !can_int)
    else $error("interrupt active while disabled");
  a_busoff_hold: assert property (@(posedge clock) disable iff (srst) // R07
    $rose(bus_off_flag) |=> hold_bit && recover_r ##1 bus_halt)
    else $error("bus-off did not set hold");
  a_recov_halt: assert property (@(posedge clock) disable iff (srst) // R08
    $fell(recover_r) && !$past(srst)
    |-> $past(bit_tick) && $past(bus_receive_pin) && !$past(hold_bit)
        && $past(bit_cnt_r) == BIT_LAST && $past(idle_cnt_r) == IDLE_LAST)
    else $error("recovery ended before the full idle count");
  a_cnt_clear: assert property (@(posedge clock) disable iff (srst) // R10
    err_cnt_clear |-> !recover_r && $past(recover_r))
    else $error("counter clear outside recovery end");
  a_rx_monitor: assert property (@(posedge clock) disable iff (srst) // R13
    reg_addr == ccc_pkg::TEST_CONTROL_ADDR
    |=> reg_rdata[7] == $past(bus_receive_pin))
    else $error("rx monitor bit wrong");
  a_tx_dominant: assert property (@(posedge clock) disable iff (srst) // R15
    test_r[ccc_pkg::TC_TX_HI:ccc_pkg::TC_TX_LO] == ccc_pkg::TX_DOMINANT
    |=> !bus_transmit_pin)
    else $error("pin not dominant in forced mode");
endmodule : ccc_core_control

// file: ccc_pkg.sv
// shared constants of the can core control and test block
package ccc_pkg;
  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] CORE_CONTROL_ADDR = 8'h00; // control register
  localparam logic [7:0] TEST_CONTROL_ADDR = 8'h0a; // test register

  // ************************************************************
  // core_control field positions
  // ************************************************************
  localparam int CC_TEST    = 7;  // test mode enable
  localparam int CC_CFG_EN  = 6;  // config_change_enable
  localparam int CC_NO_RETX = 5;  // retransmit_disable
  localparam int CC_ERR_IE  = 3;  // error_irq_enable
  localparam int CC_STAT_IE = 2;  // status_change_irq_enable
  localparam int CC_MIE     = 1;  // module_irq_enable
  localparam int CC_INIT    = 0;  // setup hold
  localparam logic [7:0] CC_RESET = 8'h01; // only the hold bit set
  localparam logic [7:0] CC_MASK  = 8'hef; // bit 4 reads as zero

  // ************************************************************
  // test_control field positions
  // ************************************************************
  localparam int TC_RX    = 7;  // live receive pin, read only
  localparam int TC_TX_HI = 6;  // transmit pin control, upper bit
  localparam int TC_TX_LO = 5;  // transmit pin control, lower bit
  localparam int TC_LOOP  = 4;  // loopback_enable
  localparam int TC_SIL   = 3;  // listen only
  localparam int TC_BASIC = 2;  // basic mode
  localparam logic [7:0] TC_RESET = 8'h00; // writable bits reset to zero
  localparam logic [7:0] TC_MASK  = 8'h7c; // writable bits

  // ************************************************************
  // transmit pin modes, interrupt code, recovery counts
  // ************************************************************
  localparam logic [1:0] TX_CORE     = 2'h0; // core drives the pin
  localparam logic [1:0] TX_SAMPLE   = 2'h1; // sample point on the pin
  localparam logic [1:0] TX_DOMINANT = 2'h2; // constant dominant
  localparam logic [1:0] TX_RECESS   = 2'h3; // constant recessive
  localparam logic [15:0] IRQ_STATUS = 16'h8000; // status interrupt code
  localparam logic [2:0]  CODE_UNUSED = 3'h7;    // code that raises nothing
  localparam int IDLE_BITS  = 11;  // recessive bits in one bus idle
  localparam int IDLE_COUNT = 129; // bus idles to leave bus-off
endpackage : ccc_pkg

// file: ccc_bus_node.sv
// far side of the bus: transceiver and other nodes as one wired-and
`timescale 1ns/100ps
module ccc_bus_node (
  input  wire logic tx_pin,     // our node's transmit pin
  input  wire logic remote_dom, // some other node drives dominant
  output logic      rx_pin      // bus level back at our receiver
);
  // ************************************************************
  // bus level
  // ************************************************************
  // dominant wins, so the receiver never sees a stale recessive level
  assign rx_pin = tx_pin & ~remote_dom;
endmodule : ccc_bus_node

// file: can_core_control_and_test_tb_top.sv
// self-checking bench for the can core control and test block
`timescale 1ns/100ps
module can_core_control_and_test_tb_top;
  localparam int NB    = 2;    // bits per idle, short for run time
  localparam int NI    = 3;    // idles per recovery, short for run time
  localparam int LIMIT = 3000; // cycle ceiling, tests need about 140
  logic        clock, srst, reg_wr, bus_off_flag, error_warning_flag;
  logic        code_wr, irq_clear, bit_tick, core_tx, sample_point;
  logic        remote_dom, bus_receive_pin, bus_transmit_pin, can_int;
  logic        config_write_ok, retransmit_disable, loopback_enable;
  logic        listen_only, basic_mode, bus_halt, err_cnt_clear;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [2:0]  last_error_code;
  logic [15:0] irq_identifier;
  int          num_errors, total_checks, cycles;

  ccc_core_control #(.IDLE_BITS(NB), .IDLE_COUNT(NI)) u_dut (
    .clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .bus_off_flag(bus_off_flag), .error_warning_flag(error_warning_flag),
    .code_wr(code_wr), .last_error_code(last_error_code),
    .irq_clear(irq_clear), .bit_tick(bit_tick), .core_tx(core_tx),
    .sample_point(sample_point), .bus_receive_pin(bus_receive_pin),
    .bus_transmit_pin(bus_transmit_pin), .irq_identifier(irq_identifier),
    .can_int(can_int), .config_write_ok(config_write_ok),
    .retransmit_disable(retransmit_disable),
    .loopback_enable(loopback_enable), .listen_only(listen_only),
    .basic_mode(basic_mode), .bus_halt(bus_halt),
    .err_cnt_clear(err_cnt_clear));

  ccc_bus_node u_node (.tx_pin(bus_transmit_pin), .remote_dom(remote_dom),
    .rx_pin(bus_receive_pin));

  // ************************************************************
  // clock, hang guard, shared tasks
  // ************************************************************
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // a hang counts as a mismatch and still reaches the report
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == LIMIT) begin
      num_errors = num_errors + 1;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one-cycle write strobe, register holds the value after the edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask : wr

  // read data is registered: look one edge after the address lands
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a;
    @(posedge clock);
    #1 chk("reg_rdata", {8'h00, reg_rdata}, {8'h00, exp});
  endtask : rd

  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
  endtask : settle

  task automatic put_code(input logic [2:0] c);
    @(posedge clock);
    code_wr         <= 1'b1;
    last_error_code <= c;
    @(posedge clock);
    code_wr         <= 1'b0;
    @(posedge clock);
    #1;
  endtask : put_code

  task automatic clr_irq();
    @(posedge clock);
    irq_clear <= 1'b1;
    @(posedge clock);
    irq_clear <= 1'b0;
    settle();
    chk("irq_identifier", irq_identifier, 16'h0000);
    chk("can_int", can_int, 16'h0000);
  endtask : clr_irq

  // one bit time; dom makes another node pull the bus dominant
  task automatic tick(input logic dom);
    @(posedge clock);
    bit_tick   <= 1'b1;
    remote_dom <= dom;
    @(posedge clock);
    bit_tick   <= 1'b0;
    remote_dom <= 1'b0;
  endtask : tick

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_test_reg();
    logic [1:0] m;
    logic       pin;
    rd(8'h0a, 8'h80);
    wr(8'h0a, 8'h40);
    rd(8'h0a, 8'h80);
    chk("bus_transmit_pin", bus_transmit_pin, 16'h0001);
    wr(8'h00, 8'h81);
    core_tx      <= 1'b0;
    sample_point <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      m   = i[1:0];
      pin = (m == 2'h0) ? 1'b0 : ((m == 2'h2) ? 1'b0 : 1'b1);
      wr(8'h0a, {1'b0, m, 5'h00});
      rd(8'h0a, {pin, m, 5'h00});
      chk("bus_transmit_pin", bus_transmit_pin, {15'h0, pin});
    end
    // sample mode again with the sample point low, unlike recessive
    wr(8'h0a, 8'h20);
    sample_point <= 1'b0;
    rd(8'h0a, 8'h20);
    chk("bus_transmit_pin", bus_transmit_pin, 16'h0000);
    wr(8'h0a, 8'h1f);
    rd(8'h0a, 8'h1c);
    chk("modes", {loopback_enable, listen_only, basic_mode}, 16'h7);
    // leave test mode the polite way: test bits first
    wr(8'h0a, 8'h00);
    wr(8'h00, 8'h01);
    core_tx <= 1'b1;
    rd(8'h0a, 8'h80);
  endtask : t_test_reg

  task automatic t_config();
    wr(8'h00, 8'hff);
    rd(8'h00, 8'hef);
    chk("config_write_ok", config_write_ok, 16'h1);
    chk("retransmit_disable", retransmit_disable, 16'h1);
    wr(8'h00, 8'h40);
    rd(8'h00, 8'h40);
    chk("config_write_ok", config_write_ok, 16'h0);
    chk("retransmit_disable", retransmit_disable, 16'h0);
  endtask : t_config

  task automatic t_irq();
    wr(8'h00, 8'h0e);
    @(posedge clock);
    error_warning_flag <= 1'b1;
    settle();
    chk("irq_identifier", irq_identifier, 16'h8000);
    chk("can_int", can_int, 16'h1);
    clr_irq();
    put_code(3'h7);
    chk("irq_identifier", irq_identifier, 16'h0000);
    put_code(3'h2);
    chk("irq_identifier", irq_identifier, 16'h8000);
    clr_irq();
    wr(8'h00, 8'h0c);
    put_code(3'h3);
    chk("irq_identifier", irq_identifier, 16'h8000);
    chk("can_int", can_int, 16'h0);
    clr_irq();
    wr(8'h00, 8'h00);
    @(posedge clock);
    error_warning_flag <= 1'b0;
    settle();
    put_code(3'h1);
    chk("irq_identifier", irq_identifier, 16'h0000);
  endtask : t_irq

  task automatic t_bus_off();
    @(posedge clock);
    bus_off_flag <= 1'b1;
    settle();
    @(posedge clock);
    bus_off_flag <= 1'b0;
    rd(8'h00, 8'h01);
    wr(8'h00, 8'h00);
    #1 chk("bus_halt", bus_halt, 16'h1);
    tick(1'b0);
    tick(1'b1);
    repeat (NB * NI - 1) tick(1'b0);
    settle();
    chk("bus_halt", bus_halt, 16'h1);
    chk("err_cnt_clear", err_cnt_clear, 16'h0);
    // a tick while held must not advance the count
    wr(8'h00, 8'h01);
    tick(1'b0);
    wr(8'h00, 8'h00);
    #1 chk("bus_halt", bus_halt, 16'h1);
    tick(1'b0);
    #1;
    chk("err_cnt_clear", err_cnt_clear, 16'h1);
    chk("bus_halt", bus_halt, 16'h0);
    settle();
    chk("err_cnt_clear", err_cnt_clear, 16'h0);
  endtask : t_bus_off

  // a second reset mid-run brings every register back to reset values
  task automatic t_reset();
    wr(8'h00, 8'h8e);
    wr(8'h0a, 8'h60);
    put_code(3'h2);
    @(posedge clock);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    rd(8'h00, 8'h01);
    rd(8'h0a, 8'h80);
    chk("irq_identifier", irq_identifier, 16'h0000);
    chk("bus_halt", bus_halt, 16'h1);
  endtask : t_reset

  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    {reg_wr, bus_off_flag, error_warning_flag, code_wr} = 4'h0;
    {irq_clear, bit_tick, sample_point, remote_dom}    = 4'h0;
    {reg_addr, reg_wdata, last_error_code}             = 19'h0;
    {srst, core_tx}                                    = 2'h3;
    {num_errors, total_checks, cycles}                 = 96'h0;
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    rd(8'h00, 8'h01);
    chk("bus_transmit_pin", bus_transmit_pin, 16'h1);
    t_test_reg();
    t_config();
    t_irq();
    t_bus_off();
    t_reset();
    end_sim();
  end
endmodule : can_core_control_and_test_tb_top
